// ===== lt_pkg.sv
// Constants, register map and fault count helper for the light threshold interrupt logic
// Contract
// - Latched: high run reaches fault count sets flag high, interrupt, ready.
// - Latched: low run reaches fault count sets flag low, interrupt, ready.
// - Conversion without fault trigger sets ready only; flags and pin unchanged.
// - Config write selecting shutdown changes no flag, pin or ready.
// - Config write selecting non-shutdown clears ready; flags and pin kept.
// - Latched: alert response drives pin inactive, flags and ready kept.
// - Transparent: high trigger makes interrupt active, flag high 1, low 0.
// - Transparent: low trigger makes interrupt inactive, flag low 1, high 0.
// - Trigger only after fault-count consecutive same-limit comparisons.
// - Transparent: config reads and writes leave pin and flags alone.
// - Transparent: alert response ignored entirely.
// - Low limit top bits 11 select end-of-conversion behaviour.
// - Pin low when active with polarity 0 or inactive with polarity 1.
// - Config read clears ready; back-to-back reads return 1 then 0.
// - Latched: flags held until config read clears them; pin held until config read or alert response.
// - Config bit 4 selects latched (1) or transparent (0) mode.
package lt_pkg;
  // Register byte addresses
  localparam logic [11:0] ADDR_CONFIG   = 12'h000;
  localparam logic [11:0] ADDR_HIGH_LIM = 12'h004;
  localparam logic [11:0] ADDR_LOW_LIM  = 12'h008;
  localparam logic [11:0] ADDR_RESULT   = 12'h00C;
  localparam logic [11:0] ADDR_IRQ_STAT = 12'h010;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h014;
  localparam logic [11:0] ADDR_CONV     = 12'h018;
  // Config field positions
  localparam int FC_LSB     = 0;
  localparam int POL_BIT    = 3;
  localparam int LATCH_BIT  = 4;
  localparam int FLAG_L_BIT = 5;
  localparam int FLAG_H_BIT = 6;
  localparam int READY_BIT  = 7;
  localparam int MODE_LSB   = 9;
  localparam int LIM_W      = 16;
  localparam int TOPB_LSB   = 14;
  // Reset values
  localparam logic [15:0] CONFIG_RST   = 16'h0010;
  localparam logic [15:0] HIGH_LIM_RST = 16'hBFFF;
  localparam logic [15:0] LOW_LIM_RST  = 16'h0000;
  localparam logic [1:0]  MODE_SHUTDN  = 2'b00;
  localparam logic [1:0]  TOPB_EOC     = 2'b11;
  // Interrupt status bits
  localparam int EV_HIGH = 0;
  localparam int EV_LOW  = 1;
  localparam int EV_CONV = 2;
  localparam int EV_W    = 3;
  // Fault count code to consecutive count: 1, 2, 4, 8
  function automatic logic [3:0] fault_need(input logic [1:0] code);
    fault_need = 4'h1 << code;
  endfunction
endpackage

// ===== lt_fault_count.sv
// Consecutive fault counter for one limit
`timescale 1ns/1ps
module lt_fault_count
  import lt_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // Conversion events
  input  wire logic       conv_done,
  input  wire logic       violate,
  input  wire logic [1:0] fc_code,
  // Trigger
  output logic            trigger
);
  logic [3:0] run_reg;
  logic [3:0] run_next;
  wire  [3:0] need = fault_need(fc_code);
  wire  [3:0] inc  = (run_reg >= need) ? need : run_reg + 4'h1;

  // Run length; restarts on a clean conversion
  assign run_next = !conv_done ? run_reg : (violate ? inc : 4'h0);
  assign trigger  = conv_done && violate && (inc >= need);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      run_reg <= 4'h0;
    end else begin
      run_reg <= run_next;
    end
  end

  run_restart_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    conv_done && !violate |=> run_reg == 4'h0) else $error("run not restarted");
  trig_needs_run_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    trigger |-> run_reg + 4'h1 >= need) else $error("trigger before run complete");
endmodule

// ===== lt_pin_sync.sv
// Three-stage synchroniser with agreement filter
`timescale 1ns/1ps
module lt_pin_sync (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_n,
  // Pin and filtered level
  input  wire logic pin_in,
  output logic      level
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  // Level changes once stages two and three agree
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      level  <= 1'b0;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) level <= s3_reg;
    end
  end
endmodule

// ===== lt_irq_logic.sv
// Light threshold interrupt logic with APB register access
`timescale 1ns/1ps
module lt_irq_logic
  import lt_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Alert response pulse from the two-wire engine (asynchronous)
  input  wire logic        alert_resp_pin,
  // Open-drain interrupt pin
  output logic             int_pin_out,
  output logic             int_pin_oe,
  // Processor interrupt
  output logic             irq
);
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_ACCESS = 2'b01} apb_e;
  apb_e        apb_reg;
  logic [15:0] config_reg;
  logic [15:0] high_lim_reg;
  logic [15:0] low_lim_reg;
  logic [15:0] result_reg;
  logic        flag_h_reg;
  logic        flag_l_reg;
  logic        ready_reg;
  logic        active_reg;
  logic [EV_W-1:0] stat_reg;
  logic [EV_W-1:0] mask_reg;
  logic [EV_W-1:0] stat_next;
  logic        alert_lvl;
  logic        alert_d_reg;
  logic [31:0] rdata_next;
  logic        trig_h;
  logic        trig_l;

  // Alert response arrives from outside this clock domain
  lt_pin_sync u_alert_sync (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .pin_in  (alert_resp_pin),
    .level   (alert_lvl)
  );

  // APB decode; one wait-free access phase
  wire access   = psel && penable;
  wire wr_en    = access && pwrite;
  wire rd_en    = access && !pwrite;
  wire hit_cfg  = paddr == ADDR_CONFIG;
  wire hit_hi   = paddr == ADDR_HIGH_LIM;
  wire hit_lo   = paddr == ADDR_LOW_LIM;
  wire hit_res  = paddr == ADDR_RESULT;
  wire hit_st   = paddr == ADDR_IRQ_STAT;
  wire hit_msk  = paddr == ADDR_IRQ_MASK;
  wire hit_conv = paddr == ADDR_CONV;
  wire mapped   = hit_cfg | hit_hi | hit_lo | hit_res | hit_st | hit_msk | hit_conv;
  wire lo_ok    = pstrb[0];
  wire hi_ok    = pstrb[1];
  assign pready  = 1'b1;
  assign pslverr = access && !mapped;

  // Configuration fields
  wire       latched   = config_reg[LATCH_BIT];
  wire       interrupt_polarity       = config_reg[POL_BIT];
  wire [1:0] fc_code   = config_reg[FC_LSB +: 2];
  wire       eoc_mode  = low_lim_reg[TOPB_LSB +: 2] == TOPB_EOC;
  wire       cfg_rd    = rd_en && hit_cfg;
  wire       cfg_wr    = wr_en && hit_cfg && lo_ok && hi_ok;
  wire [1:0] wr_mode   = pwdata[MODE_LSB +: 2];
  wire       cfg_wr_on = cfg_wr && (wr_mode != MODE_SHUTDN);
  wire       alert_ev  = alert_lvl && !alert_d_reg;

  // A write to the conversion slot (ADDR_CONV) stands in for a finished conversion
  wire       conv_done = wr_en && hit_conv && lo_ok && hi_ok;
  wire [15:0] conv_val = pwdata[15:0];
  wire       over      = conv_val > high_lim_reg;
  wire       under     = (conv_val < low_lim_reg) && !eoc_mode;

  // Independent run counters per limit
  lt_fault_count u_fc_high (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .conv_done (conv_done),
    .violate   (over),
    .fc_code   (fc_code),
    .trigger   (trig_h)
  );
  lt_fault_count u_fc_low (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .conv_done (conv_done),
    .violate   (under),
    .fc_code   (fc_code),
    .trigger   (trig_l)
  );

  // Flag high next value
  wire flag_h_next =
      trig_h                        ? 1'b1 :
      (trig_l && !latched)          ? 1'b0 :
      (cfg_rd && latched)           ? 1'b0 :
      flag_h_reg;
  // Flag low next value
  wire flag_l_next =
      trig_l                        ? 1'b1 :
      (trig_h && !latched)          ? 1'b0 :
      (cfg_rd && latched)           ? 1'b0 :
      flag_l_reg;
  // Interrupt state next value; events win over clears
  wire eoc_clear = cfg_rd || (alert_ev && latched) || (cfg_wr_on && !latched);
  wire active_next =
      (eoc_mode && conv_done)       ? 1'b1 :
      trig_h                        ? 1'b1 :
      trig_l                        ? latched :
      (eoc_mode && eoc_clear)       ? 1'b0 :
      (latched && cfg_rd)           ? 1'b0 :
      (latched && alert_ev)         ? 1'b0 :
      active_reg;
  // Conversion ready next value
  wire ready_next =
      conv_done                     ? 1'b1 :
      (cfg_rd || cfg_wr_on)         ? 1'b0 :
      ready_reg;

  // Sticky status, read clears, a new event wins
  assign stat_next = (rd_en && hit_st ? {EV_W{1'b0}} : stat_reg)
                   | {conv_done, trig_l, trig_h};
  assign irq = |(stat_reg & mask_reg);

  // Open-drain pin: low when active with pol 0, inactive with pol 1
  assign int_pin_out = 1'b0;
  assign int_pin_oe  = active_reg ^ interrupt_polarity;

  // Read data mux
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (hit_cfg) begin
      rdata_next[15:0]       = config_reg;
      rdata_next[FLAG_L_BIT] = flag_l_reg;
      rdata_next[FLAG_H_BIT] = flag_h_reg;
      rdata_next[READY_BIT]  = ready_reg;
    end else if (hit_hi)  rdata_next[15:0] = high_lim_reg;
    else if (hit_lo)  rdata_next[15:0] = low_lim_reg;
    else if (hit_res) rdata_next[15:0] = result_reg;
    else if (hit_st)  rdata_next[EV_W-1:0] = stat_reg;
    else if (hit_msk) rdata_next[EV_W-1:0] = mask_reg;
  end

  // APB phase tracking
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) apb_reg <= ST_IDLE;
    else apb_reg <= (psel && !penable) ? ST_ACCESS : ST_IDLE;
  end

  // Read data register, captured in the setup cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite) prdata <= rdata_next;
  end

  // Software-written registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      config_reg   <= CONFIG_RST;
      high_lim_reg <= HIGH_LIM_RST;
      low_lim_reg  <= LOW_LIM_RST;
      mask_reg     <= {EV_W{1'b0}};
    end else if (wr_en && lo_ok && hi_ok) begin
      if (hit_cfg) config_reg <= pwdata[15:0];
      if (hit_hi)  high_lim_reg <= pwdata[15:0];
      if (hit_lo)  low_lim_reg <= pwdata[15:0];
      if (hit_msk) mask_reg <= pwdata[EV_W-1:0];
    end
  end

  // Reporting state
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_h_reg  <= 1'b0;
      flag_l_reg  <= 1'b0;
      ready_reg   <= 1'b0;
      active_reg  <= 1'b0;
      stat_reg    <= {EV_W{1'b0}};
      result_reg  <= 16'h0000;
      alert_d_reg <= 1'b0;
    end else begin
      flag_h_reg  <= flag_h_next;
      flag_l_reg  <= flag_l_next;
      ready_reg   <= ready_next;
      active_reg  <= active_next;
      stat_reg    <= stat_next;
      alert_d_reg <= alert_lvl;
      if (conv_done) result_reg <= conv_val;
    end
  end

  // Checks
  latch_high_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    trig_h && latched |=> flag_h_reg && active_reg && ready_reg && flag_l_reg == $past(flag_l_reg))
    else $error("latched high trigger wrong");
  latch_low_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    trig_l && !trig_h && latched |=> flag_l_reg && active_reg && ready_reg)
    else $error("latched low trigger wrong");
  no_trig_keep_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    conv_done && !trig_h && !trig_l && !eoc_mode && !cfg_rd && !alert_ev |=>
    ready_reg && $stable(flag_h_reg) && $stable(flag_l_reg) && $stable(active_reg))
    else $error("plain conversion changed flags");
  shutdown_wr_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cfg_wr && wr_mode == MODE_SHUTDN && !conv_done && !alert_ev |=>
    $stable(ready_reg) && $stable(active_reg) && $stable(flag_h_reg))
    else $error("shutdown write changed state");
  run_wr_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cfg_wr_on && !conv_done |=> !ready_reg) else $error("ready not cleared");
  alert_pin_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    alert_ev && latched && !conv_done |=> !active_reg && $stable(flag_h_reg))
    else $error("alert response not honoured");
  transp_high_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    trig_h && !latched |=> active_reg && flag_h_reg && !flag_l_reg)
    else $error("transparent high wrong");
  transp_low_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    trig_l && !trig_h && !latched && !eoc_mode |=> !active_reg && flag_l_reg && !flag_h_reg)
    else $error("transparent low wrong");
  transp_cfg_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !latched && !eoc_mode && !conv_done && (cfg_rd || alert_ev) |=> $stable(active_reg))
    else $error("transparent pin disturbed");
  pin_drive_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    int_pin_oe == ((active_reg && !interrupt_polarity) || (!active_reg && interrupt_polarity)))
    else $error("pin polarity wrong");
  read_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cfg_rd && !conv_done |=> !ready_reg && (!$past(latched) || (!flag_h_reg && !flag_l_reg)))
    else $error("config read did not clear");
  cv_latched: cover property (@(posedge sys_clk) disable iff (!rst_n) trig_h && latched);
  cv_transp: cover property (@(posedge sys_clk) disable iff (!rst_n) trig_l && !latched);
  cv_alert: cover property (@(posedge sys_clk) disable iff (!rst_n) alert_ev && active_reg);
  cv_eoc: cover property (@(posedge sys_clk) disable iff (!rst_n) eoc_mode && conv_done);
endmodule

// ===== lt_host_model.sv
// Host side model: pulled-up interrupt line and alert response requests
`timescale 1ns/1ps
module lt_host_model (
  // Clock
  input  wire logic sys_clk,
  // Open-drain interrupt pin from the device
  input  wire logic int_pin_out,
  input  wire logic int_pin_oe,
  // Resolved line and alert response request
  output logic      int_wire,
  output logic      alert_resp_pin
);
  // Pull-up resistor: the line is high unless the device drives it
  assign int_wire = int_pin_oe ? int_pin_out : 1'b1;

  initial begin
    alert_resp_pin = 1'b0;
  end

  // Alert response request, held long enough for the device synchroniser
  task automatic send_alert();
    @(posedge sys_clk);
    alert_resp_pin <= 1'b1;
    repeat (4) @(posedge sys_clk);
    alert_resp_pin <= 1'b0;
    repeat (6) @(posedge sys_clk);
  endtask
endmodule

// ===== light_threshold_interrupt_logic_tb.sv
// Self-checking testbench of the light threshold interrupt logic
`timescale 1ns/1ps
module light_threshold_interrupt_logic_tb
  import lt_pkg::*;
;
  logic        sys_clk;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        alert_resp_pin;
  logic        int_pin_out;
  logic        int_pin_oe;
  logic        int_wire;
  logic        irq;
  int          errors;
  int          samples_checked;

  // Device and host model
  lt_irq_logic dut (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .alert_resp_pin(alert_resp_pin), .int_pin_out(int_pin_out), .int_pin_oe(int_pin_oe), .irq(irq));
  lt_host_model host (.sys_clk(sys_clk), .int_pin_out(int_pin_out), .int_pin_oe(int_pin_oe),
    .int_wire(int_wire), .alert_resp_pin(alert_resp_pin));

  // Clock generator, 50 ns period
  always #25 sys_clk = ~sys_clk;

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One APB transfer, waiting for pready at the access edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      chk("pready", 32'h0000_0001, 32'h0000_0000);
    end
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, {16'h0000, d}, q, e);
  endtask

  task automatic rd(input logic [11:0] a, input logic [15:0] exp);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, q, e);
    chk("read data", {16'h0000, exp}, {16'h0000, q[15:0]});
  endtask

  // Conversion with a given result, then time for the pin to settle
  task automatic conv(input logic [15:0] r);
    wr(ADDR_CONV, r);
    repeat (3) @(posedge sys_clk);
  endtask

  task automatic pin(input logic exp);
    chk("int line", {31'h0, exp}, {31'h0, int_wire});
  endtask

  task automatic t_reset();
    pin(1'b1);
    chk("irq", 32'h0000_0000, {31'h0, irq});
    rd(ADDR_CONFIG, CONFIG_RST);
    rd(ADDR_HIGH_LIM, HIGH_LIM_RST);
    rd(ADDR_LOW_LIM, LOW_LIM_RST);
  endtask

  task automatic t_latched();
    wr(ADDR_HIGH_LIM, 16'h03E8);
    wr(ADDR_LOW_LIM, 16'h0064);
    wr(ADDR_IRQ_MASK, 16'h0007);
    wr(ADDR_CONFIG, 16'h0011);
    conv(16'h07D0);
    pin(1'b1);
    rd(ADDR_CONFIG, 16'h0091);
    conv(16'h01F4);
    conv(16'h07D0);
    pin(1'b1);
    conv(16'h07D0);
    pin(1'b0);
    chk("irq", 32'h0000_0001, {31'h0, irq});
    rd(ADDR_IRQ_STAT, 16'h0005);
    repeat (2) @(posedge sys_clk);
    chk("irq", 32'h0000_0000, {31'h0, irq});
    rd(ADDR_CONFIG, 16'h00D1);
    rd(ADDR_CONFIG, 16'h0011);
    repeat (2) @(posedge sys_clk);
    pin(1'b1);
  endtask

  task automatic t_alert_cfg();
    conv(16'h0032);
    conv(16'h0032);
    pin(1'b0);
    rd(ADDR_IRQ_STAT, 16'h0006);
    wr(ADDR_CONFIG, 16'h0011);
    repeat (2) @(posedge sys_clk);
    pin(1'b0);
    host.send_alert();
    pin(1'b1);
    rd(ADDR_CONFIG, 16'h00B1);
    wr(ADDR_IRQ_MASK, 16'h0000);
    conv(16'h01F4);
    chk("irq", 32'h0000_0000, {31'h0, irq});
    rd(ADDR_IRQ_STAT, 16'h0004);
    wr(ADDR_CONFIG, 16'h0211);
    rd(ADDR_CONFIG, 16'h0211);
  endtask

  task automatic t_transparent();
    wr(ADDR_CONFIG, 16'h0208);
    repeat (2) @(posedge sys_clk);
    pin(1'b0);
    conv(16'h07D0);
    pin(1'b1);
    rd(ADDR_CONFIG, 16'h02C8);
    rd(ADDR_CONFIG, 16'h0248);
    host.send_alert();
    pin(1'b1);
    wr(ADDR_CONFIG, 16'h0208);
    repeat (2) @(posedge sys_clk);
    pin(1'b1);
    conv(16'h0032);
    pin(1'b0);
    rd(ADDR_CONFIG, 16'h02A8);
  endtask

  task automatic t_eoc();
    logic [31:0] q;
    logic        e;
    wr(ADDR_HIGH_LIM, 16'hFFFF);
    wr(ADDR_LOW_LIM, 16'hC000);
    wr(ADDR_CONFIG, 16'h0011);
    conv(16'h01F4);
    pin(1'b0);
    rd(ADDR_CONFIG, 16'h00B1);
    repeat (2) @(posedge sys_clk);
    pin(1'b1);
    apb(1'b0, 12'h020, 32'h0000_0000, q, e);
    chk("pslverr", 32'h0000_0001, {31'h0, e});
    chk("unmapped data", 32'h0000_0000, q);
  endtask

  // Watchdog against a hung handshake
  initial begin
    #(50 * 5000);
    errors++;
    print_verdict();
  end

  // Reset, then the scenarios in order
  initial begin
    sys_clk = 1'b0;
    rst_n   = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0000_0000;
    errors  = 0;
    samples_checked = 0;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    t_reset();
    t_latched();
    t_alert_cfg();
    t_transparent();
    t_eoc();
    print_verdict();
  end
endmodule
